// file: pkg/nsw_consts.svh
// register offsets, field positions and codes for the status word bank
// assumes word-addressed file registers, one 16-bit word per index
`ifndef NSW_CONSTS_SVH
`define NSW_CONSTS_SVH
`define NSW_OFS_AUX2_LO     8'h2c
`define NSW_OFS_AUX2_HI     8'h2d
`define NSW_OFS_TOOL_GRP    8'h37
`define NSW_OFS_BATT        8'h38
`define NSW_OFS_STANDBY     8'h3c
`define NSW_OFS_INIT_ACT    8'h3e
`define NSW_OFS_INIT_INC    8'h3f
`define NSW_OFS_SCR_PAGE    8'h40
`define NSW_OFS_SCR_FUNC    8'h41
`define NSW_OFS_SCR_3       8'h42
`define NSW_OFS_SCR_4       8'h43
`define NSW_OFS_SCAN        8'h44
`define NSW_OFS_ESTOP       8'h45
`define NSW_BATT_LOW_BIT    0
`define NSW_SB_AUX_WAIT     0
`define NSW_SB_RAPID_DEC    1
`define NSW_SB_CUT_DEC      2
`define NSW_SB_ORIENT       3
`define NSW_SB_POS_LOOP     4
`define NSW_SB_DOOR         7
`define NSW_SB_DWELL        8
`define NSW_SB_UNCLAMP      11
`define NSW_PAGE_FIRST      8'h01
`define NSW_MENU_MAX        8'h13
`define NSW_FN_TOOL_A       8'h0c
`define NSW_FN_TOOL_B       8'h12
`define NSW_FN_EDIT         8'h0d
`define NSW_FN_DIAG         8'h10
`define NSW_FN_GRAPH        8'h08
`define NSW_ESTOP_IDLE      16'hffff
`endif

// file: pkg/nsw_pkg.sv
// types for the status word bank
// assumes nsw_consts.svh holds the numbers
package nsw_pkg;
  typedef enum logic [1:0] {
    NSW_LET_A = 2'h0,
    NSW_LET_B = 2'h1,
    NSW_LET_C = 2'h2
  } nsw_letter_t;
  typedef enum logic [1:0] {
    NSW_SC_IDLE = 2'h0,
    NSW_SC_CHG  = 2'h1,
    NSW_SC_DONE = 2'h3
  } nsw_scr_st_t;
endpackage

// file: design/nsw_status_bank.sv
// status word bank presented by the controller to the ladder program
// assumes event inputs are one-cycle pulses synchronous to sys_clk
`timescale 1ns/1ps
`include "nsw_consts.svh"

module nsw_status_bank #(
  parameter int NAXES = 4
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // power-up and battery
  input  wire logic              power_on_pulse,
  input  wire logic              battery_low,
  output logic                   battery_alarm_in,
  // tool code commands within a block
  input  wire logic              tool_cmd_valid,
  input  wire logic [31:0]       tool_cmd_bcd,
  input  wire logic              block_end,
  output logic [31:0]            tool_code_word,
  output logic                   tool_func_strobe,
  // second auxiliary function commands
  input  wire logic              aux2_cmd_valid,
  input  wire logic              aux2_cmd_auto,
  input  wire logic              aux2_cmd_manual,
  input  wire logic [1:0]        aux2_cmd_letter,
  input  wire logic [31:0]       aux2_cmd_bcd,
  input  wire logic [1:0]        second_aux_letter_param,
  input  wire logic [2:0]        axis_letter_used,
  output logic                   second_aux_strobe,
  output logic                   aux2_letter_bad,
  input  wire logic              aux_finish_one,
  input  wire logic              aux_finish_two,
  // tool life, standby, scan, emergency stop
  input  wire logic [15:0]       tool_group_in,
  input  wire logic [15:0]       standby_cause_in,
  input  wire logic              scan_done,
  input  wire logic [15:0]       scan_time_in,
  input  wire logic [15:0]       estop_active_in,
  // absolute position per axis
  input  wire logic [NAXES-1:0]  init_select,
  input  wire logic [NAXES-1:0]  zero_point_init_mode,
  input  wire logic [NAXES-1:0]  abs_pos_valid,
  output logic [NAXES-1:0]       stroke_limit_enable,
  output logic [NAXES-1:0]       stroke_end_enable,
  output logic [NAXES-1:0]       init_current_limit,
  // screen keys
  input  wire logic              func_key,
  input  wire logic [7:0]        func_code,
  input  wire logic              menu_key,
  input  wire logic [7:0]        menu_num,
  input  wire logic              page_next,
  input  wire logic              page_prev,
  // ladder read port
  input  wire logic [7:0]        rd_index,
  output logic [15:0]            rd_data
);

  // held words
  logic [31:0]      tool_pend_r;
  logic             tool_have_r;
  logic [31:0]      tool_word_r;
  logic             tool_stb_r;
  logic             tool_go_r;
  logic [31:0]      aux2_pend_r;
  logic             aux2_have_r;
  logic [31:0]      aux2_word_r;
  logic             aux2_stb_r;
  logic             aux2_go_r;
  logic [15:0]      group_r;
  logic [15:0]      batt_r;
  logic [15:0]      standby_r;
  logic [NAXES-1:0] init_hold_r;
  logic [NAXES-1:0] init_act;
  logic [NAXES-1:0] init_inc;
  logic [15:0]      page_word_r;
  logic [15:0]      func_word_r;
  logic [15:0]      scan_r;
  logic [15:0]      estop_r;
  nsw_pkg::nsw_scr_st_t scr_st_r;
  nsw_pkg::nsw_scr_st_t scr_st_nxt;

  // letter is usable when one of A/B/C and not an axis name
  function automatic logic letter_ok(input logic [1:0] l,
                                     input logic [2:0] used);
    letter_ok = (l <= 2'(nsw_pkg::NSW_LET_C)) && !used[l];
  endfunction

  // tool code: keep latest in the block, publish at block end
  // last code wins
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      tool_pend_r <= 32'h0;
      tool_have_r <= 1'b0;
    end
    else if (block_end)
    begin
      tool_have_r <= 1'b0;
    end
    else if (tool_cmd_valid)
    begin
      tool_pend_r <= tool_cmd_bcd;
      tool_have_r <= 1'b1;
    end
  end

  // tool word held through reset; strobe follows one cycle after data
  // data before strobe
  always_ff @(posedge sys_clk)
  begin
    if (power_on_pulse || (block_end && tool_have_r))
      tool_word_r <= power_on_pulse ? 32'h0 : tool_pend_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      tool_go_r  <= 1'b0;
      tool_stb_r <= 1'b0;
    end
    else
    begin
      tool_go_r <= block_end && tool_have_r;
      if (tool_go_r)
        tool_stb_r <= 1'b1;
      else if (aux_finish_one || aux_finish_two)
        tool_stb_r <= 1'b0;
    end
  end

  // second aux: last valid code of the block, auto or manual source
  // auto or manual
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      aux2_pend_r <= 32'h0;
      aux2_have_r <= 1'b0;
    end
    else if (block_end)
    begin
      aux2_have_r <= 1'b0;
    end
    else if (aux2_cmd_valid && (aux2_cmd_auto || aux2_cmd_manual) &&
             aux2_cmd_letter == second_aux_letter_param &&
             letter_ok(second_aux_letter_param, axis_letter_used))
    begin
      aux2_pend_r <= aux2_cmd_bcd;
      aux2_have_r <= 1'b1;
    end
  end

  // not cleared by reset or finish
  always_ff @(posedge sys_clk)
  begin
    if (power_on_pulse || (block_end && aux2_have_r))
      aux2_word_r <= power_on_pulse ? 32'h0 : aux2_pend_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      aux2_go_r  <= 1'b0;
      aux2_stb_r <= 1'b0;
    end
    else
    begin
      aux2_go_r <= block_end && aux2_have_r;
      if (aux2_go_r)
        aux2_stb_r <= 1'b1;
      else if (aux_finish_one || aux_finish_two)
        aux2_stb_r <= 1'b0;
    end
  end

  // tool life group and standby causes
  // group word
  always_ff @(posedge sys_clk)
  begin
    group_r   <= tool_group_in;
    standby_r <= 16'h0;
    standby_r[`NSW_SB_AUX_WAIT]  <= standby_cause_in[`NSW_SB_AUX_WAIT];
    standby_r[`NSW_SB_RAPID_DEC] <= standby_cause_in[`NSW_SB_RAPID_DEC];
    standby_r[`NSW_SB_CUT_DEC]   <= standby_cause_in[`NSW_SB_CUT_DEC];
    standby_r[`NSW_SB_ORIENT]    <= standby_cause_in[`NSW_SB_ORIENT];
    standby_r[`NSW_SB_POS_LOOP]  <= standby_cause_in[`NSW_SB_POS_LOOP];
    standby_r[`NSW_SB_DOOR]      <= standby_cause_in[`NSW_SB_DOOR];
    standby_r[`NSW_SB_DWELL]     <= standby_cause_in[`NSW_SB_DWELL];
    standby_r[`NSW_SB_UNCLAMP]   <= standby_cause_in[`NSW_SB_UNCLAMP];
  end

  // battery: checked at power-on, cleared only when voltage recovers
  // power-on check
  always_ff @(posedge sys_clk)
  begin
    if (power_on_pulse)
    begin
      batt_r                    <= 16'h0;
      batt_r[`NSW_BATT_LOW_BIT] <= battery_low;
    end
    else if (!battery_low)
      batt_r[`NSW_BATT_LOW_BIT] <= 1'b0;
  end
  assign battery_alarm_in = batt_r[`NSW_BATT_LOW_BIT];

  // per-axis initialisation state
  generate
    for (genvar g = 0; g < NAXES; g++)
    begin : g_axis
      always_ff @(posedge sys_clk)
      begin
        if (power_on_pulse)
          init_hold_r[g] <= 1'b0;
        else if (init_select[g])
          init_hold_r[g] <= 1'b1;
      end
      assign init_act[g] = init_hold_r[g] || zero_point_init_mode[g];
      assign init_inc[g] = !abs_pos_valid[g];
      assign stroke_limit_enable[g] = !init_act[g] && !init_inc[g];
      assign stroke_end_enable[g]   = !init_act[g];
      assign init_current_limit[g]  = init_act[g];
    end
  endgenerate

  // screen words: change only on a key that picks a new screen
  // key-driven update
  always_comb
  begin
    scr_st_nxt = nsw_pkg::NSW_SC_IDLE;
    case (scr_st_r)
      nsw_pkg::NSW_SC_IDLE:
        if (func_key || menu_key || page_next || page_prev)
          scr_st_nxt = nsw_pkg::NSW_SC_CHG;
      nsw_pkg::NSW_SC_CHG:  scr_st_nxt = nsw_pkg::NSW_SC_DONE;
      nsw_pkg::NSW_SC_DONE: scr_st_nxt = nsw_pkg::NSW_SC_IDLE;
      default:              scr_st_nxt = nsw_pkg::NSW_SC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      scr_st_r <= nsw_pkg::NSW_SC_IDLE;
    else
      scr_st_r <= scr_st_nxt;
  end

  // page upper byte, low byte zero
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      page_word_r <= {`NSW_PAGE_FIRST, 8'h00};
      func_word_r <= 16'h0;
    end
    else if (scr_st_r == nsw_pkg::NSW_SC_IDLE)
    begin
      if (func_key && func_code != func_word_r[15:8])
      begin
        func_word_r <= {func_code, 8'h00};
        page_word_r <= {`NSW_PAGE_FIRST, 8'h00};
      end
      else if (menu_key && menu_num <= `NSW_MENU_MAX &&
               menu_num != func_word_r[7:0])
      begin
        func_word_r[7:0] <= menu_num;
        page_word_r <= {`NSW_PAGE_FIRST, 8'h00};
      end
      else if (page_next && page_word_r[15:8] != 8'hff)
        page_word_r[15:8] <= page_word_r[15:8] + 8'h01;
      else if (page_prev && page_word_r[15:8] > `NSW_PAGE_FIRST)
        page_word_r[15:8] <= page_word_r[15:8] - 8'h01;
    end
  end

  // scan time and emergency stop causes, active low per cause
  // scan refresh
  always_ff @(posedge sys_clk)
  begin
    if (scan_done)
      scan_r <= scan_time_in;
    if (!resetn)
      estop_r <= `NSW_ESTOP_IDLE;
    else
      estop_r <= ~estop_active_in;
  end

  // ladder read mux
  // third and fourth screen words read zero
  always_comb
  begin
    rd_data = 16'h0;
    case (rd_index)
      `NSW_OFS_AUX2_LO:  rd_data = aux2_word_r[15:0];
      `NSW_OFS_AUX2_HI:  rd_data = aux2_word_r[31:16];
      `NSW_OFS_TOOL_GRP: rd_data = group_r;
      `NSW_OFS_BATT:     rd_data = batt_r;
      `NSW_OFS_STANDBY:  rd_data = standby_r;
      `NSW_OFS_INIT_ACT: rd_data = 16'(init_act);
      `NSW_OFS_INIT_INC: rd_data = 16'(init_inc);
      `NSW_OFS_SCR_PAGE: rd_data = page_word_r;
      `NSW_OFS_SCR_FUNC: rd_data = func_word_r;
      `NSW_OFS_SCAN:     rd_data = scan_r;
      `NSW_OFS_ESTOP:    rd_data = estop_r;
      default:           rd_data = 16'h0;
    endcase
  end

  assign tool_code_word    = tool_word_r;
  assign tool_func_strobe  = tool_stb_r;
  assign second_aux_strobe = aux2_stb_r;
  assign aux2_letter_bad   =
    !letter_ok(second_aux_letter_param, axis_letter_used);

  // checks, all on sys_clk and masked while reset is held
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  last_tool_a: assert property (tool_cmd_valid && !block_end
    ##1 block_end |=> tool_word_r == $past(tool_cmd_bcd, 2))
    else $error("tool word not last code");
  tool_order_a: assert property ($rose(tool_stb_r) |->
    $stable(tool_word_r))
    else $error("tool word moved with strobe");
  aux2_keep_a: assert property (!(block_end && aux2_have_r) &&
    !power_on_pulse |=> $stable(aux2_word_r))
    else $error("second aux word changed");
  aux2_last_a: assert property (block_end && aux2_have_r |=>
    aux2_word_r == $past(aux2_pend_r))
    else $error("second aux not last code");
  aux2_strobe_a: assert property (block_end && aux2_have_r |->
    ##2 aux2_stb_r)
    else $error("second aux strobe missing");
  batt_set_a: assert property (power_on_pulse && battery_low |=>
    batt_r[0] ##0 battery_alarm_in)
    else $error("battery bit not set");
  init_mode_a: assert property (
    (zero_point_init_mode & ~init_act) == '0)
    else $error("init mode not reflected");
  init_limit_a: assert property (
    (stroke_limit_enable & ~abs_pos_valid) == '0)
    else $error("stroke limit not disabled");
  estop_low_a: assert property (estop_active_in[0] |=>
    !estop_r[0])
    else $error("estop cause not low");
  page_low_a: assert property (page_word_r[7:0] == 8'h00 &&
    func_word_r[7:0] <= 8'h13)
    else $error("screen word field out of range");
  tool_cov_c:   cover property (@(posedge sys_clk) $rose(tool_stb_r));
  aux2_cov_c:   cover property (@(posedge sys_clk) $rose(aux2_stb_r));
  batt_cov_c:   cover property (@(posedge sys_clk) $fell(batt_r[0]));
  screen_cov_c: cover property (@(posedge sys_clk)
    scr_st_r == nsw_pkg::NSW_SC_DONE);

endmodule // nsw_status_bank

// file: bench/nsw_ladder_model.sv
// ladder program side: answers function strobes with a finish signal
// assumes strobes are registered levels on sys_clk, finish held till drop
`timescale 1ns/1ps

module nsw_ladder_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // strobes and code word from the controller
  input  wire logic        tool_func_strobe,
  input  wire logic        second_aux_strobe,
  input  wire logic [31:0] tool_code_word,
  input  wire logic [3:0]  fin_delay,
  // finish answers and the code seen at strobe rise
  output logic             aux_finish_one,
  output logic             aux_finish_two,
  output logic [31:0]      seen_code
);
  int wait_cnt;

  // count strobe cycles, answer after fin_delay, release when strobe drops
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wait_cnt <= 0;
      aux_finish_one <= 1'b0;
      aux_finish_two <= 1'b0;
    end
    else if (tool_func_strobe || second_aux_strobe)
    begin
      wait_cnt <= wait_cnt + 1;
      aux_finish_one <= tool_func_strobe && (wait_cnt >= fin_delay);
      aux_finish_two <= second_aux_strobe && (wait_cnt >= fin_delay);
    end
    else
    begin
      wait_cnt <= 0;
      aux_finish_one <= 1'b0;
      aux_finish_two <= 1'b0;
    end
  end

  // sample code word
  // the ladder reads the word in the first strobe cycle; it must be settled
  always_ff @(posedge sys_clk)
  begin
    if (tool_func_strobe && wait_cnt == 0)
      seen_code <= tool_code_word;
  end
endmodule // nsw_ladder_model

// file: bench/nsw_status_bank_tb_top.sv
// self-checking bench for the status word bank with a ladder partner
// assumes nsw_consts.svh on the include path, 100 MHz sys_clk
`timescale 1ns/1ps
`include "nsw_consts.svh"

module nsw_status_bank_tb_top;
  localparam int NAXES = 4;
  // design and partner signals
  logic sys_clk, resetn, power_on_pulse, battery_low, battery_alarm_in;
  logic tool_cmd_valid, block_end, tool_func_strobe, second_aux_strobe;
  logic aux2_cmd_valid, aux2_cmd_auto, aux2_cmd_manual, aux2_letter_bad;
  logic aux_finish_one, aux_finish_two, scan_done;
  logic func_key, menu_key, page_next, page_prev;
  logic [31:0] tool_cmd_bcd, aux2_cmd_bcd, tool_code_word, seen_code;
  logic [1:0]  aux2_cmd_letter, second_aux_letter_param;
  logic [2:0]  axis_letter_used;
  logic [15:0] tool_group_in, standby_cause_in, scan_time_in;
  logic [15:0] estop_active_in, rd_data;
  logic [NAXES-1:0] init_select, zero_point_init_mode, abs_pos_valid;
  logic [NAXES-1:0] stroke_limit_enable, stroke_end_enable;
  logic [NAXES-1:0] init_current_limit;
  logic [7:0]  func_code, menu_num, rd_index;
  logic [3:0]  fin_delay;
  // bench model state
  int bad_count, n_tests, seed, fn, mn, pg, i, k;
  logic [31:0] t_exp, a_exp, q[$];

  nsw_status_bank #(.NAXES(NAXES)) i_nsw_status_bank (.*);
  nsw_ladder_model i_nsw_ladder_model (.*);

  // free-running 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // counts and verdict, the only end of the run
  task give_verdict();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // compare a port value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t port got %h exp %h", $time, got, exp);
    end
  endtask

  // compare a word read through the ladder read port
  task rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    @(posedge sys_clk);
    rd_index <= idx;
    #2;
    n_tests++;
    if (rd_data !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t word %h got %h exp %h", $time, idx, rd_data,
               exp);
    end
  endtask

  // several codes in one block, then block end; ok says it is accepted
  task run_blk(input int n, input bit ax, input bit ok);
    logic [31:0] c;
    int j;
    q.delete();
    for (j = 0; j < n; j++)
    begin
      @(posedge sys_clk);
      c = $random(seed) & 32'h77777777;
      if (ax)
        aux2_cmd_bcd <= c;
      else
        tool_cmd_bcd <= c;
      aux2_cmd_valid <= ax;
      tool_cmd_valid <= !ax;
      q.push_back(c);
    end
    @(posedge sys_clk);
    tool_cmd_valid <= 1'b0;
    aux2_cmd_valid <= 1'b0;
    block_end <= 1'b1;
    @(posedge sys_clk);
    block_end <= 1'b0;
    #1;
    if (ax && ok)
      a_exp = q[$];
    if (!ax)
      t_exp = q[$];
    chk(tool_code_word, t_exp);
    @(posedge sys_clk);
    #1;
    chk(ax ? second_aux_strobe : tool_func_strobe, ok);
    for (j = 0; j < 40 && (ax ? second_aux_strobe : tool_func_strobe); j++)
      @(posedge sys_clk);
    if (j == 40)
    begin
      bad_count++;
      $display("MISMATCH %0t strobe never dropped", $time);
      give_verdict();
    end
    if (!ax)
      chk(seen_code, t_exp);
    rd_chk(`NSW_OFS_AUX2_LO, a_exp[15:0]);
    rd_chk(`NSW_OFS_AUX2_HI, a_exp[31:16]);
  endtask

  // one screen key: 0 function, 1 menu, 2 next page, 3 previous page
  task key(input int kd, input logic [7:0] v);
    @(posedge sys_clk);
    func_key <= (kd == 0);
    menu_key <= (kd == 1);
    page_next <= (kd == 2);
    page_prev <= (kd == 3);
    func_code <= v;
    menu_num <= v;
    @(posedge sys_clk);
    {func_key, menu_key, page_next, page_prev} <= 4'h0;
    if (kd == 0 && v != fn)
      {fn, mn, pg} = {32'(v), 32'h0, 32'h1};
    if (kd == 1 && v <= `NSW_MENU_MAX && v != mn)
      {mn, pg} = {32'(v), 32'h1};
    if (kd == 2 && pg < 255)
      pg++;
    if (kd == 3 && pg > 1)
      pg--;
    repeat (3) @(posedge sys_clk);
    rd_chk(`NSW_OFS_SCR_PAGE, {8'(pg), 8'h00});
    rd_chk(`NSW_OFS_SCR_FUNC, {8'(fn), 8'(mn)});
  endtask

  // main sequence
  initial
  begin
    seed = 25;
    {bad_count, n_tests, fn, mn, pg} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    {resetn, power_on_pulse, battery_low, tool_cmd_valid, block_end} = 0;
    {aux2_cmd_valid, aux2_cmd_auto, aux2_cmd_manual, scan_done} = 0;
    {func_key, menu_key, page_next, page_prev, axis_letter_used} = 0;
    {tool_cmd_bcd, aux2_cmd_bcd, aux2_cmd_letter} = 0;
    {second_aux_letter_param, tool_group_in, standby_cause_in} = 0;
    {scan_time_in, estop_active_in, init_select} = 0;
    {zero_point_init_mode, abs_pos_valid, func_code, menu_num} = 0;
    rd_index = 8'h00;
    fin_delay = 4'h1;
    {t_exp, a_exp} = 64'h0;
    // power comes up while reset is held
    power_on_pulse = 1'b1;
    repeat (4) @(posedge sys_clk);
    power_on_pulse <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    rd_chk(`NSW_OFS_ESTOP, `NSW_ESTOP_IDLE);
    rd_chk(`NSW_OFS_SCR_3, 16'h0000);
    rd_chk(`NSW_OFS_SCR_4, 16'h0000);
    // battery low at power-on, held until the voltage is back
    battery_low <= 1'b1;
    power_on_pulse <= 1'b1;
    @(posedge sys_clk);
    power_on_pulse <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(battery_alarm_in, 1'b1);
    rd_chk(`NSW_OFS_BATT, 16'h0001);
    battery_low <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd_chk(`NSW_OFS_BATT, 16'h0000);
    // tool blocks, partner quick then slow
    run_blk(1, 0, 1);
    fin_delay <= 4'h6;
    run_blk(3, 0, 1);
    // second aux for each letter, accepted and refused cases
    for (k = 0; k < 3; k++)
    begin
      second_aux_letter_param <= 2'(k);
      axis_letter_used <= 3'h0;
      aux2_cmd_letter <= 2'(k);
      {aux2_cmd_auto, aux2_cmd_manual} <= 2'b10;
      run_blk(2, 1, 1);
      aux2_cmd_letter <= 2'((k + 1) % 3);
      run_blk(1, 1, 0);
      aux2_cmd_letter <= 2'(k);
      {aux2_cmd_auto, aux2_cmd_manual} <= 2'b01;
      run_blk(1, 1, 1);
      {aux2_cmd_auto, aux2_cmd_manual} <= 2'b00;
      run_blk(1, 1, 0);
      {aux2_cmd_auto, aux2_cmd_manual} <= 2'b10;
      axis_letter_used <= 3'(1 << k);
      #1;
      chk(aux2_letter_bad, 1'b1);
      run_blk(1, 1, 0);
    end
    // reset in mid-run keeps the held code words
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    chk(tool_code_word, t_exp);
    rd_chk(`NSW_OFS_AUX2_LO, a_exp[15:0]);
    rd_chk(`NSW_OFS_AUX2_HI, a_exp[31:16]);
    // random status levels and scan latching
    for (k = 0; k < 4; k++)
    begin
      tool_group_in <= 16'($random(seed));
      standby_cause_in <= 16'($random(seed));
      estop_active_in <= 16'($random(seed));
      scan_time_in <= 16'($random(seed));
      scan_done <= 1'b1;
      @(posedge sys_clk);
      scan_done <= 1'b0;
      scan_time_in <= ~scan_time_in;
      repeat (2) @(posedge sys_clk);
      rd_chk(`NSW_OFS_TOOL_GRP, tool_group_in);
      rd_chk(`NSW_OFS_STANDBY, standby_cause_in & 16'h099f);
      rd_chk(`NSW_OFS_ESTOP, ~estop_active_in);
      rd_chk(`NSW_OFS_SCAN, ~scan_time_in);
    end
    // axis initialisation holds, mode input and lost positions
    abs_pos_valid <= 4'b0110;
    init_select <= 4'b0001;
    zero_point_init_mode <= 4'b0100;
    @(posedge sys_clk);
    init_select <= 4'b0000;
    repeat (3) @(posedge sys_clk);
    rd_chk(`NSW_OFS_INIT_ACT, 16'h0005);
    rd_chk(`NSW_OFS_INIT_INC, 16'h0009);
    chk(stroke_limit_enable, 4'b0010);
    chk(stroke_end_enable, 4'b1010);
    chk(init_current_limit, 4'b0101);
    zero_point_init_mode <= 4'b0000;
    repeat (3) @(posedge sys_clk);
    rd_chk(`NSW_OFS_INIT_ACT, 16'h0001);
    // screen keys, including ignored menu and the lower page bound
    key(0, `NSW_FN_EDIT);
    key(1, 8'h05);
    key(1, 8'h14);
    key(1, `NSW_MENU_MAX);
    key(2, 8'h00);
    key(2, 8'h00);
    key(3, 8'h00);
    key(0, `NSW_FN_EDIT);
    key(3, 8'h00);
    key(3, 8'h00);
    key(0, `NSW_FN_TOOL_A);
    key(0, `NSW_FN_TOOL_B);
    key(0, `NSW_FN_DIAG);
    key(0, `NSW_FN_GRAPH);
    give_verdict();
  end
endmodule // nsw_status_bank_tb_top
